// ===== rtl/jfd_defs.svh
// constants of the fault diagnostics manager
`ifndef JFD_DEFS_SVH
`define JFD_DEFS_SVH

`define JFD_CLK_NS        50
`define JFD_TICK_NS       1000000
`define JFD_HOLDOFF_MS    5000
`define JFD_PERIOD_MS     1000
`define JFD_REACT_MS      3000

`define JFD_BLK_BASE      10'h000
`define JFD_BLK_STRIDE    10'h010
`define JFD_W_CTRL        2'h0
`define JFD_W_ID          2'h1
`define JFD_W_THR         2'h2
`define JFD_W_HYST        2'h3
`define JFD_REACT_BASE    10'h100
`define JFD_REACT_STRIDE  10'h004
`define JFD_SRC_ADDR      10'h120
`define JFD_STATUS        10'h124

`define JFD_SRC_ANY       8'hFF
`define JFD_SRC_MIN       8'h01
`define JFD_SRC_MAX       8'hFD
`define JFD_GLOBAL_ADDR   8'hFF
`define JFD_LAMP_ON       2'h1
`define JFD_OC_MAX        7'h7F
`define JFD_CM_VALUE      1'b0

`define JFD_FMI_1         5'h01
`define JFD_FMI_0         5'h00
`define JFD_FMI_4         5'h04
`define JFD_FMI_3         5'h03
`define JFD_FMI_5         5'h05
`define JFD_FMI_6         5'h06
`define JFD_FMI_17        5'h11
`define JFD_FMI_15        5'h0F
`define JFD_FMI_18        5'h12
`define JFD_FMI_16        5'h10
`define JFD_FMI_21        5'h15
`define JFD_FMI_20        5'h14

`endif

// ===== rtl/jfd_pkg.sv
// types of the fault diagnostics manager
package jfd_pkg;

    typedef enum logic [1:0] {JFD_LAMP_MIL, JFD_LAMP_RED, JFD_LAMP_AMBER, JFD_LAMP_PROTECT} jfd_lamp_t;
    typedef enum logic [1:0] {JFD_RQ_DM1, JFD_RQ_DM2, JFD_RQ_DM3, JFD_RQ_DM11} jfd_rq_t;
    typedef enum logic [1:0] {JFD_MSG_DM1, JFD_MSG_DM2} jfd_msg_t;
    typedef enum logic [1:0] {JFD_TX_SINGLE, JFD_TX_BAM, JFD_TX_TP} jfd_mode_t;

    typedef struct packed {
        logic [6:0]  oc;
        logic        cm;
        logic [4:0]  fmi;
        logic [18:0] spn;
    } jfd_dtc_t;

    typedef struct packed {
        logic [1:0] mil;
        logic [1:0] red;
        logic [1:0] amber;
        logic [1:0] protect;
    } jfd_lamp_byte_t;

    typedef struct packed {
        logic [15:0] delayMs;
        logic [5:0]  rsvHi;
        jfd_lamp_t   lamp;
        logic [5:0]  rsvLo;
        logic        clrDm11;
        logic        genDtc;
    } jfd_ctrl_word_t;

    typedef struct packed {
        logic [7:0]  rsv;
        logic [4:0]  fmi;
        logic [18:0] spn;
    } jfd_id_word_t;

    typedef struct packed {
        logic [1:0]  rsv;
        jfd_lamp_t   lamp;
        logic [3:0]  rsv2;
        logic [4:0]  fmi;
        logic [18:0] spn;
    } jfd_react_word_t;

    typedef struct packed {
        jfd_ctrl_word_t ctrl;
        jfd_id_word_t   id;
        logic [15:0]    maxThr;
        logic [15:0]    minThr;
        logic [15:0]    hyst;
    } jfd_blk_cfg_t;

    typedef struct packed {
        logic     valid;
        jfd_rq_t  kind;
        logic [7:0] srcAddr;
    } jfd_req_t;

    typedef struct packed {
        logic           valid;
        logic [7:0]     srcAddr;
        jfd_lamp_byte_t lamps;
        logic [18:0]    spn;
        logic [4:0]     fmi;
    } jfd_rx_dtc_t;

    typedef struct packed {
        logic           valid;
        jfd_msg_t       msg;
        jfd_mode_t      mode;
        logic [7:0]     dest;
        logic [4:0]     count;
        jfd_lamp_byte_t lamps;
    } jfd_tx_t;

endpackage

// ===== rtl/jfd_fault_diag.sv
// fault diagnostics manager: fault qualify, dtc build, dm1/dm2 scheduling, dtc react
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "jfd_defs.svh"

module jfd_fault_diag
    import jfd_pkg::*;
#(
    parameter int NBLK       = 4,
    parameter int NREACT     = 5,
    parameter int TICK_CYC   = `JFD_TICK_NS / `JFD_CLK_NS,
    parameter int HOLDOFF_MS = `JFD_HOLDOFF_MS,
    parameter int PERIOD_MS  = `JFD_PERIOD_MS,
    parameter int REACT_MS   = `JFD_REACT_MS
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [9:0]                 regAddr,
    input  wire logic [31:0]                regWrData,
    input  wire logic                       regWrStb,
    input  wire logic                       regRdStb,
    output      logic [31:0]                regRdData,
    input  wire logic [NBLK-1:0][15:0]      measVal,
    input  wire logic [NBLK-1:0]            evalGate,
    input  wire jfd_req_t                   rxReq,
    input  wire jfd_rx_dtc_t                rxDtc,
    output      jfd_tx_t                    txReq,
    output      jfd_dtc_t [2*NBLK-1:0]      dtcTable,
    output      logic [2*NBLK-1:0]          dtcActive,
    output      logic [NREACT-1:0]          reactState
);

    localparam int NSLOT = 2 * NBLK;

    function automatic logic [4:0] fmiHigh(input logic [4:0] lo);
        case (lo)
            `JFD_FMI_1:  fmiHigh = `JFD_FMI_0;
            `JFD_FMI_4:  fmiHigh = `JFD_FMI_3;
            `JFD_FMI_5:  fmiHigh = `JFD_FMI_6;
            `JFD_FMI_17: fmiHigh = `JFD_FMI_15;
            `JFD_FMI_18: fmiHigh = `JFD_FMI_16;
            `JFD_FMI_21: fmiHigh = `JFD_FMI_20;
            default:     fmiHigh = lo;
        endcase
    endfunction

    function automatic logic [4:0] popCount(input logic [NSLOT-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int k = 0; k < NSLOT; k++) begin
            n = n + {4'h0, v[k]};
        end
        popCount = n;
    endfunction

    function automatic logic lampOn(input jfd_lamp_byte_t lb, input jfd_lamp_t sel);
        case (sel)
            JFD_LAMP_MIL:   lampOn = (lb.mil == `JFD_LAMP_ON);
            JFD_LAMP_RED:   lampOn = (lb.red == `JFD_LAMP_ON);
            JFD_LAMP_AMBER: lampOn = (lb.amber == `JFD_LAMP_ON);
            default:        lampOn = (lb.protect == `JFD_LAMP_ON);
        endcase
    endfunction

    // ---------------- millisecond tick
    logic [$clog2(TICK_CYC+1)-1:0] tickCnt_reg;
    logic                          msTick;

    assign msTick = (tickCnt_reg == ($bits(tickCnt_reg))'(TICK_CYC - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_reg <= '0;
        end else if (msTick) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
        end
    end

    // ---------------- register port
    jfd_blk_cfg_t [NBLK-1:0]       cfg_reg;
    jfd_react_word_t [NREACT-1:0]  react_reg;
    logic [7:0]                    srcAddr_reg;
    logic [NBLK-1:0]               idChg;
    logic [6:0]                    oc_reg [NSLOT];
    logic                          blkRegion;
    logic [2:0]                    blkSel;
    logic [1:0]                    wordSel;

    assign blkRegion = (regAddr[9:7] == 3'(`JFD_BLK_BASE >> 7)) && (32'(regAddr[6:4]) < NBLK);
    assign blkSel    = regAddr[6:4];
    assign wordSel   = regAddr[3:2];

    // any write that alters spn or fmi resets the log of that block
    always_comb begin
        for (int b = 0; b < NBLK; b++) begin
            idChg[b] = regWrStb && blkRegion && (32'(blkSel) == b) && (wordSel == `JFD_W_ID)
                       && (regWrData[23:0] != {cfg_reg[b].id.fmi, cfg_reg[b].id.spn});
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg     <= '0;
            react_reg   <= '0;
            srcAddr_reg <= `JFD_SRC_ANY;
        end else if (regWrStb) begin
            for (int b = 0; b < NBLK; b++) begin
                if (blkRegion && 32'(blkSel) == b) begin
                    case (wordSel)
                        `JFD_W_CTRL: cfg_reg[b].ctrl <= jfd_ctrl_word_t'(regWrData);
                        `JFD_W_ID:   cfg_reg[b].id   <= jfd_id_word_t'({8'h00, regWrData[23:0]});
                        `JFD_W_THR:  {cfg_reg[b].maxThr, cfg_reg[b].minThr} <= regWrData;
                        default:     cfg_reg[b].hyst <= regWrData[15:0];
                    endcase
                end
            end
            for (int r = 0; r < NREACT; r++) begin
                if (regAddr == 10'(`JFD_REACT_BASE + r * `JFD_REACT_STRIDE)) begin
                    react_reg[r] <= jfd_react_word_t'(regWrData);
                end
            end
            if (regAddr == `JFD_SRC_ADDR) begin
                srcAddr_reg <= regWrData[7:0];
            end
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    logic [31:0] rdMux;

    always_comb begin
        rdMux = 32'h0000_0000;
        for (int b = 0; b < NBLK; b++) begin
            if (blkRegion && 32'(blkSel) == b) begin
                case (wordSel)
                    `JFD_W_CTRL: rdMux = cfg_reg[b].ctrl;
                    `JFD_W_ID:   rdMux = cfg_reg[b].id;
                    `JFD_W_THR:  rdMux = {cfg_reg[b].maxThr, cfg_reg[b].minThr};
                    default:     rdMux = {1'b0, oc_reg[2*b+1], 1'b0, oc_reg[2*b],
                                          cfg_reg[b].hyst};
                endcase
            end
        end
        for (int r = 0; r < NREACT; r++) begin
            if (regAddr == 10'(`JFD_REACT_BASE + r * `JFD_REACT_STRIDE)) begin
                rdMux = react_reg[r];
            end
        end
        if (regAddr == `JFD_SRC_ADDR) begin
            rdMux = {24'h00_0000, srcAddr_reg};
        end
        if (regAddr == `JFD_STATUS) begin
            rdMux = {8'(reactState), 8'h00, 16'(dtcActive)};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= regRdStb ? rdMux : 32'h0000_0000;
        end
    end

    // ---------------- per-slot fault qualify; slot 2b is low end, 2b+1 high end
    logic       dm3Req;
    logic       dm11Req;
    logic [NSLOT-1:0] flag_reg;
    logic [NSLOT-1:0] active_reg;

    assign dm3Req  = rxReq.valid && (rxReq.kind == JFD_RQ_DM3);
    assign dm11Req = rxReq.valid && (rxReq.kind == JFD_RQ_DM11);
    assign dtcActive = active_reg;

    genvar s;
    generate
        for (s = 0; s < NSLOT; s++) begin : g_slot
            localparam int B  = s / 2;
            localparam bit HI = (s % 2) == 1;
            logic [15:0] timer_reg;
            logic        gen;
            logic [16:0] valPlusHyst;
            logic [16:0] minPlusHyst;
            logic        setCond;
            logic        clrCond;
            logic        qualify;

            assign gen         = cfg_reg[B].ctrl.genDtc;
            assign valPlusHyst = {1'b0, measVal[B]} + {1'b0, cfg_reg[B].hyst};
            assign minPlusHyst = {1'b0, cfg_reg[B].minThr} + {1'b0, cfg_reg[B].hyst};
            assign setCond = HI ? (measVal[B] > cfg_reg[B].maxThr)
                                : (measVal[B] < cfg_reg[B].minThr);
            // written as value plus hysteresis so a hysteresis above max cannot wrap
            assign clrCond = HI ? (valPlusHyst <= {1'b0, cfg_reg[B].maxThr})
                                : ({1'b0, measVal[B]} >= minPlusHyst);
            assign qualify = gen && flag_reg[s] && !active_reg[s]
                             && (timer_reg >= cfg_reg[B].ctrl.delayMs);

            // gate low freezes the flag: open-circuit feedback is meaningless when off
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flag_reg[s] <= 1'b0;
                end else if (!gen) begin
                    flag_reg[s] <= 1'b0;
                end else if (evalGate[B]) begin
                    if (!flag_reg[s] && setCond) begin
                        flag_reg[s] <= 1'b1;
                    end else if (flag_reg[s] && clrCond) begin
                        flag_reg[s] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    timer_reg <= 16'h0000;
                end else if (!gen || !flag_reg[s] || active_reg[s]) begin
                    timer_reg <= 16'h0000;
                end else if (msTick && !qualify) begin
                    timer_reg <= timer_reg + 16'h0001;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    active_reg[s] <= 1'b0;
                end else if (!gen) begin
                    active_reg[s] <= 1'b0;
                end else if (qualify) begin
                    active_reg[s] <= 1'b1;
                end else if (dm11Req) begin
                    active_reg[s] <= 1'b0;
                end else if (active_reg[s] && !flag_reg[s] && !cfg_reg[B].ctrl.clrDm11) begin
                    active_reg[s] <= 1'b0;
                end
            end

            // counts are volatile here; the non-volatile copy is kept outside
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    oc_reg[s] <= 7'h00;
                end else if (idChg[B]) begin
                    oc_reg[s] <= 7'h00;
                end else if (qualify) begin
                    if (oc_reg[s] != `JFD_OC_MAX) begin
                        oc_reg[s] <= oc_reg[s] + 7'h01;
                    end
                end else if (dm3Req && !active_reg[s]) begin
                    oc_reg[s] <= 7'h00;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    dtcTable[s] <= '0;
                end else begin
                    dtcTable[s].oc  <= oc_reg[s];
                    dtcTable[s].cm  <= `JFD_CM_VALUE;
                    dtcTable[s].spn <= cfg_reg[B].id.spn;
                    // unmapped codes pass through, so both ends report alike
                    dtcTable[s].fmi <= HI ? fmiHigh(cfg_reg[B].id.fmi)
                                          : cfg_reg[B].id.fmi;
                end
            end
        end
    endgenerate

    // ---------------- lamp byte
    jfd_lamp_byte_t lampByte;

    always_comb begin
        lampByte = '0;
        for (int k = 0; k < NSLOT; k++) begin
            if (active_reg[k]) begin
                case (cfg_reg[k/2].ctrl.lamp)
                    JFD_LAMP_MIL:   lampByte.mil     = `JFD_LAMP_ON;
                    JFD_LAMP_RED:   lampByte.red     = `JFD_LAMP_ON;
                    JFD_LAMP_AMBER: lampByte.amber   = `JFD_LAMP_ON;
                    default:        lampByte.protect = `JFD_LAMP_ON;
                endcase
            end
        end
    end

    // ---------------- dm1 scheduling
    logic [NSLOT-1:0]              prevActive_reg;
    logic [$clog2(HOLDOFF_MS+1)-1:0] hold_reg;
    logic [$clog2(PERIOD_MS+1)-1:0]  period_reg;
    logic                          holdDone;
    logic                          anyGen;
    logic [4:0]                    activeCnt;
    logic [4:0]                    prevCnt;
    logic [NSLOT-1:0]              ocNz;
    logic                          periodDue;
    logic                          changeDue;
    logic                          pend_reg;
    logic                          reqServe;

    assign holdDone  = (hold_reg == ($bits(hold_reg))'(HOLDOFF_MS));
    assign activeCnt = popCount(active_reg);
    assign prevCnt   = popCount(ocNz);
    assign periodDue = msTick && (period_reg == ($bits(period_reg))'(PERIOD_MS - 1));
    assign changeDue = |(active_reg & ~prevActive_reg)
                       || ((|prevActive_reg) && !(|active_reg));
    assign reqServe  = rxReq.valid && (rxReq.kind == JFD_RQ_DM1 || rxReq.kind == JFD_RQ_DM2);

    always_comb begin
        anyGen = 1'b0;
        for (int b = 0; b < NBLK; b++) begin
            anyGen = anyGen | cfg_reg[b].ctrl.genDtc;
        end
    end

    // a process, not a function call, so count changes are seen at once
    always_comb begin
        for (int k = 0; k < NSLOT; k++) begin
            ocNz[k] = (oc_reg[k] != 7'h00);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_reg <= '0;
        end else if (msTick && !holdDone) begin
            hold_reg <= hold_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            period_reg <= '0;
        end else if (!anyGen || !holdDone || periodDue) begin
            period_reg <= '0;
        end else if (msTick) begin
            period_reg <= period_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevActive_reg <= '0;
        end else begin
            prevActive_reg <= active_reg;
        end
    end

    // a broadcast waits while a request is answered in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= 1'b0;
        end else if (!anyGen || !holdDone) begin
            pend_reg <= 1'b0;
        end else if (periodDue || changeDue) begin
            pend_reg <= 1'b1;
        end else if (!reqServe) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txReq <= '0;
        end else begin
            txReq       <= '0;
            txReq.lamps <= lampByte;
            if (reqServe && rxReq.kind == JFD_RQ_DM1) begin
                txReq.valid <= 1'b1;
                txReq.msg   <= JFD_MSG_DM1;
                txReq.dest  <= rxReq.srcAddr;
                txReq.count <= activeCnt;
                txReq.mode  <= (activeCnt > 5'h01) ? JFD_TX_TP : JFD_TX_SINGLE;
            end else if (reqServe) begin
                txReq.valid <= 1'b1;
                txReq.msg   <= JFD_MSG_DM2;
                txReq.dest  <= rxReq.srcAddr;
                txReq.count <= prevCnt;
                txReq.mode  <= (prevCnt > 5'h01) ? JFD_TX_TP : JFD_TX_SINGLE;
            end else if (pend_reg) begin
                txReq.valid <= 1'b1;
                txReq.msg   <= JFD_MSG_DM1;
                txReq.dest  <= `JFD_GLOBAL_ADDR;
                txReq.count <= activeCnt;
                txReq.mode  <= (activeCnt > 5'h01) ? JFD_TX_BAM : JFD_TX_SINGLE;
            end
        end
    end

    // ---------------- dtc react
    logic srcOk;

    assign srcOk = (srcAddr_reg == `JFD_SRC_ANY) || (rxDtc.srcAddr == srcAddr_reg);

    genvar r;
    generate
        for (r = 0; r < NREACT; r++) begin : g_react
            logic [$clog2(REACT_MS+1)-1:0] age_reg;
            logic                          hit;

            assign hit = rxDtc.valid && srcOk && (rxDtc.spn == react_reg[r].spn)
                         && (rxDtc.fmi == react_reg[r].fmi)
                         && lampOn(rxDtc.lamps, react_reg[r].lamp);

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    reactState[r] <= 1'b0;
                    age_reg       <= '0;
                end else if (hit) begin
                    reactState[r] <= 1'b1;
                    age_reg       <= '0;
                end else if (reactState[r] && msTick) begin
                    if (age_reg == ($bits(age_reg))'(REACT_MS - 1)) begin
                        reactState[r] <= 1'b0;
                        age_reg       <= '0;
                    end else begin
                        age_reg <= age_reg + 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule // jfd_fault_diag

// ===== test/jfd_checker.sv
// assertion checker for the fault diagnostics manager
`timescale 1ns/1ns
module jfd_checker
    import jfd_pkg::*;
#(parameter int NBLK = 4, parameter int NREACT = 5) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire jfd_req_t              rxReq,
    input wire jfd_rx_dtc_t           rxDtc,
    input wire jfd_tx_t               txReq,
    input wire jfd_dtc_t [2*NBLK-1:0] dtcTable,
    input wire logic [2*NBLK-1:0]     dtcActive,
    input wire logic [NREACT-1:0]     reactState
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    cm_zero_a: assert property (dtcTable[0].cm == 1'b0) else $error("cm bit set");
    oc_step_a: assert property (
        $rose(dtcActive[0]) |=> dtcTable[0].oc == $past(dtcTable[0].oc) + 7'h01)
        else $error("count not stepped");
    req_answer_a: assert property (
        rxReq.valid && rxReq.kind inside {JFD_RQ_DM1, JFD_RQ_DM2}
        |=> txReq.valid && txReq.dest == $past(rxReq.srcAddr)) else $error("no answer");
    dm2_msg_a: assert property (
        rxReq.valid && rxReq.kind == JFD_RQ_DM2 |=> txReq.msg == JFD_MSG_DM2)
        else $error("wrong answer kind");
    tp_mode_a: assert property (
        txReq.valid && txReq.dest != 8'hFF && txReq.count > 5'h01 |-> txReq.mode == JFD_TX_TP)
        else $error("directed not tp");
    bam_mode_a: assert property (
        txReq.valid && txReq.dest == 8'hFF && txReq.count > 5'h01 |-> txReq.mode == JFD_TX_BAM)
        else $error("broadcast not bam");
    single_mode_a: assert property (
        txReq.valid && txReq.count <= 5'h01 |-> txReq.mode == JFD_TX_SINGLE)
        else $error("short list not single");
    react_set_a: assert property (
        $rose(reactState[0]) |-> $past(rxDtc.valid)) else $error("reaction without dtc");
    react_keep_a: assert property (
        $fell(reactState[0]) |-> !$past(rxDtc.valid)) else $error("reaction dropped on hit");
endmodule // jfd_checker

bind jfd_fault_diag jfd_checker #(.NBLK(NBLK), .NREACT(NREACT)) chk (.*);

// ===== test/jfd_ecu_model.sv
// model of a foreign node sending requests and dm1 dtcs
`timescale 1ns/1ns
module jfd_ecu_model
    import jfd_pkg::*;
(
    input  wire logic clk,
    output jfd_req_t  rxReq,
    output jfd_rx_dtc_t rxDtc
);
    initial begin
        rxReq = '0;
        rxDtc = '0;
    end
    task automatic request(input jfd_rq_t k, input logic [7:0] src);
        rxReq <= {1'b1, k, src};
        @(posedge clk);
        rxReq <= '0;
    endtask
    task automatic send_dtc(input logic [7:0] src, input logic [7:0] lamps,
                            input logic [18:0] spn, input logic [4:0] fmi);
        rxDtc <= {1'b1, src, lamps, spn, fmi};
        @(posedge clk);
        rxDtc <= '0;
    endtask
endmodule // jfd_ecu_model

// ===== test/jfd_fault_diag_tb.sv
// self-checking bench of the fault diagnostics manager
`timescale 1ns/1ns
module jfd_fault_diag_tb;
    import jfd_pkg::*;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [9:0]       regAddr = '0;
    logic [31:0]      regWrData = '0;
    logic             regWrStb = 1'b0;
    logic             regRdStb = 1'b0;
    logic [31:0]      regRdData;
    logic [0:0][15:0] measVal = 16'h0080;
    logic [0:0]       evalGate = 1'b1;
    jfd_req_t         rxReq;
    jfd_rx_dtc_t      rxDtc;
    jfd_tx_t          txReq;
    jfd_dtc_t [1:0]   dtcTable;
    logic [1:0]       dtcActive;
    logic [4:0]       reactState;
    int miscompares = 0, total_checks = 0, cyc = 0, firstBc = -1;
    // short tick so holdoff, period and reaction fit a brief run
    jfd_fault_diag #(.NBLK(1), .TICK_CYC(20), .HOLDOFF_MS(5), .PERIOD_MS(4), .REACT_MS(3)) DUT (.*);
    jfd_ecu_model ecu (.clk(clk), .rxReq(rxReq), .rxDtc(rxDtc));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (txReq.valid === 1'b1 && txReq.dest === 8'hFF && firstBc < 0) firstBc <= cyc;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_act(input int s);
        repeat (200) if (dtcActive[s] !== 1'b1) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1 chk("regRdData", regRdData, exp);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(10'h120, 32'h000000FF);
        rd(10'h3FC, 32'h00000000);
        wr(10'h000, 32'h00020201);
        wr(10'h004, 32'h0027F001);
        wr(10'h008, 32'h01000010);
        wr(10'h00C, 32'h00000008);
        measVal <= 16'h000F;
        wait_act(0);
        tk(3);
        chk("lowDtc", dtcTable[0], 32'h0227F001);
        measVal <= 16'h0017;
        tk(5);
        chk("lowHeld", dtcActive, 2'b01);
        measVal <= 16'h0018;
        tk(5);
        chk("lowGone", dtcActive, 2'b00);
        measVal <= 16'h0101;
        wait_act(1);
        tk(3);
        chk("highFmi", dtcTable[1].fmi, 5'h03);
        measVal <= 16'h00F9;
        tk(5);
        chk("highHeld", dtcActive, 2'b10);
        measVal <= 16'h00F8;
        tk(5);
        chk("highGone", dtcActive, 2'b00);
        $display("threshold test done");
        rd(10'h00C, 32'h01010008);
        wr(10'h004, 32'h0027F002);
        rd(10'h00C, 32'h00000008);
        wr(10'h000, 32'h00020203);
        measVal <= 16'h000F;
        wait_act(0);
        measVal <= 16'h0101;
        wait_act(1);
        measVal <= 16'h0080;
        tk(5);
        chk("latched", dtcActive, 2'b11);
        ecu.request(JFD_RQ_DM1, 8'h33);
        #1 chk("dm1Tp", {txReq.mode, txReq.count}, {JFD_TX_TP, 5'h02});
        chk("lamps", txReq.lamps, 8'h04);
        ecu.request(JFD_RQ_DM11, 8'h33);
        tk(2);
        chk("dm11", dtcActive, 2'b00);
        ecu.request(JFD_RQ_DM2, 8'h33);
        #1 chk("dm2Tp", {txReq.msg, txReq.count}, {JFD_MSG_DM2, 5'h02});
        ecu.request(JFD_RQ_DM3, 8'h33);
        tk(2);
        rd(10'h00C, 32'h00000008);
        chk("holdoff", firstBc >= 105, 1'b1);
        $display("request test done");
        wr(10'h000, 32'h00000000);
        measVal <= 16'h000F;
        tk(70);
        chk("genOff", dtcActive, 2'b00);
        wr(10'h100, 32'h10100ABC);
        wr(10'h120, 32'h00000021);
        ecu.send_dtc(8'h22, 8'h10, 19'h00ABC, 5'h02);
        tk(1);
        chk("filtered", reactState[0], 1'b0);
        ecu.send_dtc(8'h21, 8'h10, 19'h00ABC, 5'h02);
        tk(1);
        chk("reactOn", reactState[0], 1'b1);
        tk(30);
        chk("reactKept", reactState[0], 1'b1);
        tk(50);
        chk("reactOff", reactState[0], 1'b0);
        $display("react test done");
        close_out();
    end
endmodule // jfd_fault_diag_tb
